// [hw/sensor_threshold_led_regs.sv]
// Purpose: Threshold and emitter drive registers with the window and
//          proximity comparators that consume them.
// Assumes: Register port and measurement inputs are synchronous.
// Notes:   Read data follows the address one cycle later.
//
// Summary of operation
// - Upper ambient bound is 16 bits, windowing visible or infrared result.
// - Upper ambient bound low byte at 0x0D, high byte at 0x0E.
// - Older silicon reads the upper ambient bound as compressed 8 bits.
// - Second emitter sinks the level in bits 7:4 during proximity.
// - First emitter sinks the level in bits 3:0 during proximity.
// - Current code 0000 is off, 0001 minimum, 1111 maximum.
// - Third emitter level from bits 3:0 at 0x10; bits 7:4 reserved.
// - Each proximity result is compared to the 16-bit proximity bound.
// - Half-updated bounds may be applied; host avoids or discards.
// - Older silicon keeps proximity bound as compressed byte at 0x11.
// - 0x0D, 0x0F and 0x11 reset to all zeros.
// - Lower ambient bound low byte 0x0B, high byte 0x0C.
// - Proximity bound high byte sits at 0x12.
`timescale 1ns/1ps
module sensor_threshold_led_regs (
  // Clock and reset
  input  wire logic                           CORE_CLK_I,
  input  wire logic                           RST_B_I,
  // Register port from the serial bus front end
  input  wire sensor_regs_pkg::reg_req_t      REG_REQ_I,
  output logic      [7:0]                     REG_RDATA_O,
  // Silicon revision select
  input  wire logic                           LEGACY_REV_I,
  // Measurement engine
  input  wire logic                           PROX_ACTIVE_I,
  input  wire sensor_regs_pkg::ambient_meas_t AMB_MEAS_I,
  input  wire sensor_regs_pkg::prox_meas_t    PROX_MEAS_I,
  // Emitter sinks and events
  output sensor_regs_pkg::emitter_drive_t     EMITTER_CURRENT_O,
  output logic                                AMB_EVENT_O,
  output logic                                PROX_EVENT_O
);
  import sensor_regs_pkg::*;

  typedef struct packed {
    logic [7:0]     amb_lower_lo;
    logic [7:0]     amb_lower_hi;
    logic [7:0]     amb_upper_lo;
    logic [7:0]     amb_upper_hi;
    logic [7:0]     emit_one_two;
    logic [3:0]     emit_three;
    logic [7:0]     prox_one_lo;
    logic [7:0]     prox_one_hi;
    logic [7:0]     rdata;
    emitter_drive_t drive;
    logic           amb_event;
    logic           prox_event;
  } state_t;

  state_t      state_reg;
  state_t      state_next;
  logic [15:0] bound_val [3];
  logic [7:0]  bound_lo  [3];
  logic [7:0]  bound_hi  [3];
  logic [15:0] amb_sel;

  // ==========================================================
  // Threshold expansion: lower ambient, upper ambient, proximity
  always_comb begin
    bound_lo[0] = state_reg.amb_lower_lo;
    bound_hi[0] = state_reg.amb_lower_hi;
    bound_lo[1] = state_reg.amb_upper_lo;
    bound_hi[1] = state_reg.amb_upper_hi;
    bound_lo[2] = state_reg.prox_one_lo;
    bound_hi[2] = state_reg.prox_one_hi;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_bound
      bound_expand u_expand (
        .lo_byte_i (bound_lo[g]),
        .hi_byte_i (bound_hi[g]),
        .legacy_i  (LEGACY_REV_I),
        .value_o   (bound_val[g])
      );
    end
  endgenerate

  // ==========================================================
  // Next state
  // Thresholds are used straight from the byte registers, so a compare
  // between two byte writes sees a mixed value; the host must pause.
  always_comb begin
    state_next = state_reg;
    amb_sel    = AMB_MEAS_I.use_ir ? AMB_MEAS_I.infrared
                                   : AMB_MEAS_I.visible;

    if (REG_REQ_I.wr) begin
      if (REG_REQ_I.addr == AMB_LOWER_LO_OFS) begin
        state_next.amb_lower_lo = REG_REQ_I.wdata;
      end else if (REG_REQ_I.addr == AMB_LOWER_HI_OFS) begin
        state_next.amb_lower_hi = REG_REQ_I.wdata;
      end else if (REG_REQ_I.addr == AMB_UPPER_LO_OFS) begin
        state_next.amb_upper_lo = REG_REQ_I.wdata;
      end else if (REG_REQ_I.addr == AMB_UPPER_HI_OFS) begin
        state_next.amb_upper_hi = REG_REQ_I.wdata;
      end else if (REG_REQ_I.addr == EMIT_ONE_TWO_OFS) begin
        state_next.emit_one_two = REG_REQ_I.wdata;
      end else if (REG_REQ_I.addr == EMIT_THREE_OFS) begin
        state_next.emit_three =
          REG_REQ_I.wdata[EMIT_THREE_LSB +: EMIT_FIELD_W];
      end else if (REG_REQ_I.addr == PROX_ONE_LO_OFS) begin
        state_next.prox_one_lo = REG_REQ_I.wdata;
      end else if (REG_REQ_I.addr == PROX_ONE_HI_OFS) begin
        state_next.prox_one_hi = REG_REQ_I.wdata;
      end
    end

    // Reads show stored values; reserved bits and holes read as zero.
    if (REG_REQ_I.addr == AMB_LOWER_LO_OFS) begin
      state_next.rdata = state_reg.amb_lower_lo;
    end else if (REG_REQ_I.addr == AMB_LOWER_HI_OFS) begin
      state_next.rdata = state_reg.amb_lower_hi;
    end else if (REG_REQ_I.addr == AMB_UPPER_LO_OFS) begin
      state_next.rdata = state_reg.amb_upper_lo;
    end else if (REG_REQ_I.addr == AMB_UPPER_HI_OFS) begin
      state_next.rdata = state_reg.amb_upper_hi;
    end else if (REG_REQ_I.addr == EMIT_ONE_TWO_OFS) begin
      state_next.rdata = state_reg.emit_one_two;
    end else if (REG_REQ_I.addr == EMIT_THREE_OFS) begin
      state_next.rdata = EMIT_THREE_MASK &
                         {4'h0, state_reg.emit_three};
    end else if (REG_REQ_I.addr == PROX_ONE_LO_OFS) begin
      state_next.rdata = state_reg.prox_one_lo;
    end else if (REG_REQ_I.addr == PROX_ONE_HI_OFS) begin
      state_next.rdata = state_reg.prox_one_hi;
    end else begin
      state_next.rdata = UNMAPPED_RD_VAL;
    end

    // Sinks carry the codes only while a proximity pulse is active;
    // code 0000 already means no current, so no extra gating.
    if (PROX_ACTIVE_I) begin
      state_next.drive.one   =
        state_reg.emit_one_two[EMIT_ONE_LSB +: EMIT_FIELD_W];
      state_next.drive.two   =
        state_reg.emit_one_two[EMIT_TWO_LSB +: EMIT_FIELD_W];
      state_next.drive.three = state_reg.emit_three;
    end else begin
      state_next.drive.one   = EMIT_CODE_OFF;
      state_next.drive.two   = EMIT_CODE_OFF;
      state_next.drive.three = EMIT_CODE_OFF;
    end

    // Window event when the selected visible or infrared result is outside [lower, upper].
    state_next.amb_event = AMB_MEAS_I.valid &&
                           ((amb_sel < bound_val[0]) ||
                            (amb_sel > bound_val[1]));
    // Proximity event on every valid result above the bound.
    state_next.prox_event = PROX_MEAS_I.valid &&
                            (PROX_MEAS_I.result > bound_val[2]);
  end

  // ==========================================================
  // State register
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg.amb_lower_lo <= REG_RESET_VAL;
      state_reg.amb_lower_hi <= REG_RESET_VAL;
      state_reg.amb_upper_lo <= REG_RESET_VAL;
      state_reg.amb_upper_hi <= REG_RESET_VAL;
      state_reg.emit_one_two <= REG_RESET_VAL;
      state_reg.emit_three   <= EMIT_CODE_OFF;
      state_reg.prox_one_lo  <= REG_RESET_VAL;
      state_reg.prox_one_hi  <= REG_RESET_VAL;
      state_reg.rdata        <= UNMAPPED_RD_VAL;
      state_reg.drive        <= '0;
      state_reg.amb_event    <= 1'b0;
      state_reg.prox_event   <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign REG_RDATA_O       = state_reg.rdata;
  assign EMITTER_CURRENT_O = state_reg.drive;
  assign AMB_EVENT_O       = state_reg.amb_event;
  assign PROX_EVENT_O      = state_reg.prox_event;

endmodule : sensor_threshold_led_regs

// [hw/sensor_regs_pkg.sv]
// Purpose: Shared constants and carrier types for the threshold and
//          emitter drive register slice.
// Assumes: Byte-wide register port driven by the serial bus front end.
// Notes:   Offsets are byte addresses on that port.
package sensor_regs_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] AMB_LOWER_LO_OFS = 8'h0B;
  localparam logic [7:0] AMB_LOWER_HI_OFS = 8'h0C;
  localparam logic [7:0] AMB_UPPER_LO_OFS = 8'h0D;
  localparam logic [7:0] AMB_UPPER_HI_OFS = 8'h0E;
  localparam logic [7:0] EMIT_ONE_TWO_OFS = 8'h0F;
  localparam logic [7:0] EMIT_THREE_OFS   = 8'h10;
  localparam logic [7:0] PROX_ONE_LO_OFS  = 8'h11;
  localparam logic [7:0] PROX_ONE_HI_OFS  = 8'h12;

  // ==========================================================
  // Reset values and field layout
  localparam logic [7:0] REG_RESET_VAL    = 8'h00;
  localparam logic [7:0] UNMAPPED_RD_VAL  = 8'h00;
  localparam logic [7:0] EMIT_THREE_MASK  = 8'h0F;
  localparam int         EMIT_ONE_LSB     = 0;
  localparam int         EMIT_TWO_LSB     = 4;
  localparam int         EMIT_THREE_LSB   = 0;
  localparam int         EMIT_FIELD_W     = 4;
  localparam logic [3:0] EMIT_CODE_OFF    = 4'h0;

  // ==========================================================
  // Compressed legacy threshold layout
  localparam int         CMP_EXP_LSB      = 4;
  localparam int         CMP_MANT_LSB     = 0;
  localparam int         CMP_FRAC_BITS    = 4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic        use_ir;
    logic [15:0] visible;
    logic [15:0] infrared;
  } ambient_meas_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] result;
  } prox_meas_t;

  typedef struct packed {
    logic [3:0] one;
    logic [3:0] two;
    logic [3:0] three;
  } emitter_drive_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : sensor_regs_pkg

// [hw/bound_expand.sv]
// Purpose: Turns a stored threshold byte pair into the 16-bit value used
//          by the comparators.
// Assumes: Legacy select is steady while a measurement is compared.
// Notes:   Pure combinational logic.
`timescale 1ns/1ps
module bound_expand (
  // Stored bytes
  input  wire logic [7:0]  lo_byte_i,
  input  wire logic [7:0]  hi_byte_i,
  // Interpretation select
  input  wire logic        legacy_i,
  // Expanded threshold
  output logic      [15:0] value_o
);
  import sensor_regs_pkg::*;

  logic [3:0]  exp_code;
  logic [20:0] widened;

  // ==========================================================
  // Expansion
  // Older silicon keeps one compressed byte: a 4-bit exponent over an
  // implied leading one and 4-bit mantissa.
  always_comb begin
    exp_code = lo_byte_i[CMP_EXP_LSB +: 4];
    widened  = 21'({1'b1, lo_byte_i[CMP_MANT_LSB +: 4]}) << exp_code;
    if (legacy_i) begin
      value_o = widened[CMP_FRAC_BITS +: 16];
    end else begin
      value_o = {hi_byte_i, lo_byte_i};
    end
  end

endmodule : bound_expand

// [dv/sensor_regs_properties.sv]
// Purpose: Port checks of the threshold and emitter register slice.
// Assumes: Legacy select is held steady while measurements are compared.
// Notes:   Shadow bytes follow host writes to predict drive and bound.
`timescale 1ns/1ps
module sensor_regs_properties
  import sensor_regs_pkg::*;
(
  input wire logic           CORE_CLK_I,
  input wire logic           RST_B_I,
  input wire reg_req_t       REG_REQ_I,
  input wire logic [7:0]     REG_RDATA_O,
  input wire logic           LEGACY_REV_I,
  input wire logic           PROX_ACTIVE_I,
  input wire ambient_meas_t  AMB_MEAS_I,
  input wire prox_meas_t     PROX_MEAS_I,
  input wire emitter_drive_t EMITTER_CURRENT_O,
  input wire logic           AMB_EVENT_O,
  input wire logic           PROX_EVENT_O
);
  logic [7:0]  drv_reg, drv3_reg, plo_reg, phi_reg;
  logic [15:0] bound;
  assign bound = {phi_reg, plo_reg};
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      {drv_reg, drv3_reg, plo_reg, phi_reg} <= '0;
    end else if (REG_REQ_I.wr) begin
      case (REG_REQ_I.addr)
        EMIT_ONE_TWO_OFS: drv_reg <= REG_REQ_I.wdata;
        EMIT_THREE_OFS:   drv3_reg <= REG_REQ_I.wdata & EMIT_THREE_MASK;
        PROX_ONE_LO_OFS:  plo_reg <= REG_REQ_I.wdata;
        PROX_ONE_HI_OFS:  phi_reg <= REG_REQ_I.wdata;
        default: ;
      endcase
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  emit_idle_a: assert property (
    !PROX_ACTIVE_I |=> EMITTER_CURRENT_O == '0)
    else $error("Emitter sink active while idle.");
  emit_follow_a: assert property (
    PROX_ACTIVE_I && !REG_REQ_I.wr |=> EMITTER_CURRENT_O ==
      {drv_reg[3:0], drv_reg[7:4], drv3_reg[3:0]})
    else $error("Emitter sink differs from drive fields.");
  prox_cmp_a: assert property (
    PROX_MEAS_I.valid && !LEGACY_REV_I |=>
      PROX_EVENT_O == ($past(PROX_MEAS_I.result) > $past(bound)))
    else $error("Proximity event disagrees with bound.");
  prox_pulse_a: assert property (
    !PROX_MEAS_I.valid |=> !PROX_EVENT_O)
    else $error("Proximity event without result.");
  amb_pulse_a: assert property (
    !AMB_MEAS_I.valid |=> !AMB_EVENT_O)
    else $error("Ambient event without result.");
  unmapped_rd_a: assert property (
    !(REG_REQ_I.addr inside {[AMB_LOWER_LO_OFS:PROX_ONE_HI_OFS]})
      |=> REG_RDATA_O == UNMAPPED_RD_VAL)
    else $error("Unmapped read returned data.");
  resv_zero_a: assert property (
    REG_REQ_I.addr == EMIT_THREE_OFS |=> REG_RDATA_O[7:4] == 4'h0)
    else $error("Reserved drive bits read nonzero.");
  rd_after_wr_a: assert property (
    REG_REQ_I.wr && REG_REQ_I.addr == AMB_UPPER_HI_OFS ##1
      !REG_REQ_I.wr && REG_REQ_I.addr == AMB_UPPER_HI_OFS
      |=> REG_RDATA_O == $past(REG_REQ_I.wdata, 2))
    else $error("Upper bound high byte read back wrong.");
endmodule : sensor_regs_properties

bind sensor_threshold_led_regs sensor_regs_properties props_u (
  .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .REG_REQ_I(REG_REQ_I),
  .REG_RDATA_O(REG_RDATA_O), .LEGACY_REV_I(LEGACY_REV_I),
  .PROX_ACTIVE_I(PROX_ACTIVE_I), .AMB_MEAS_I(AMB_MEAS_I),
  .PROX_MEAS_I(PROX_MEAS_I), .EMITTER_CURRENT_O(EMITTER_CURRENT_O),
  .AMB_EVENT_O(AMB_EVENT_O), .PROX_EVENT_O(PROX_EVENT_O));

// [dv/host_model.sv]
// Purpose: Host processor model driving the byte register port.
// Assumes: One-cycle write strobe and registered read data.
// Notes:   Requests change at the falling edge.
`timescale 1ns/1ps
module host_model
  import sensor_regs_pkg::*;
#(
  parameter int EMITTERS = 3
) (
  input  wire logic       clk_i,
  output reg_req_t        req_o,
  input  wire logic [7:0] rdata_i
);
  initial req_o = '0;
  // Bounds are rewritten only between measurements, never during one.
  task automatic write_reg(input logic [7:0] a,
                           input logic [7:0] d);
    if (a == EMIT_ONE_TWO_OFS && EMITTERS < 2) d[7:4] = 4'h0;
    if (a == EMIT_THREE_OFS && EMITTERS < 3) d[3:0] = 4'h0;
    @(negedge clk_i);
    req_o <= '{addr: a, wr: 1'b1, wdata: d};
    @(negedge clk_i);
    req_o.wr <= 1'b0;
    req_o.wdata <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_o.addr <= a;
    @(negedge clk_i);
    d = rdata_i;
  endtask : read_reg
endmodule : host_model

// [dv/sensor_threshold_led_regs_test.sv]
// Purpose: Register, emitter and comparator tests of the slice.
// Assumes: Inputs change at the falling edge.
// Notes:   Expected values are worked out from the register layout.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
  miscompares++; $display("Error %s expected %h seen %h", what, exp, got); \
  end end
module sensor_threshold_led_regs_test;
  import sensor_regs_pkg::*;
  logic           clk, rst_b, legacy, prox_act, amb_evt, prox_evt;
  logic [7:0]     rdata;
  reg_req_t       req;
  ambient_meas_t  amb;
  prox_meas_t     prox;
  emitter_drive_t drive;
  int             miscompares = 0;
  int             n_tests = 0;
  logic [3:0]     codes [3] = '{4'h0, 4'h1, 4'hF};
  host_model #(.EMITTERS(3)) host_u (.clk_i(clk), .req_o(req),
    .rdata_i(rdata));
  sensor_threshold_led_regs dut_u (.CORE_CLK_I(clk), .RST_B_I(rst_b),
    .REG_REQ_I(req), .REG_RDATA_O(rdata), .LEGACY_REV_I(legacy),
    .PROX_ACTIVE_I(prox_act), .AMB_MEAS_I(amb), .PROX_MEAS_I(prox),
    .EMITTER_CURRENT_O(drive), .AMB_EVENT_O(amb_evt),
    .PROX_EVENT_O(prox_evt));
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.read_reg(a, d);
    `CHK("read data", e, d)
  endtask : chk_reg
  task automatic m_prox(input logic [15:0] r, input logic e);
    @(negedge clk) prox <= '{valid: 1'b1, result: r};
    @(negedge clk) prox.valid <= 1'b0;
    `CHK("prox event", e, prox_evt)
  endtask : m_prox
  task automatic m_amb(input logic ir, input logic [15:0] v, i,
                       input logic e);
    @(negedge clk) amb <= '{valid: 1'b1, use_ir: ir, visible: v, infrared: i};
    @(negedge clk) amb.valid <= 1'b0;
    `CHK("ambient event", e, amb_evt)
  endtask : m_amb
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is under a thousand cycles; five times that means a hang.
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
  initial begin
    {rst_b, legacy, prox_act, amb, prox} = '0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    for (int a = 8'h0A; a <= 8'h13; a++) chk_reg(8'(a), 8'h00);
    $display("test reset_values done");
    for (int a = 8'h0A; a <= 8'h13; a++) begin
      logic [7:0] exp_rd;
      exp_rd = 8'h5A ^ 8'(a);
      if (a == EMIT_THREE_OFS) exp_rd = exp_rd & EMIT_THREE_MASK;
      if (a < AMB_LOWER_LO_OFS || a > PROX_ONE_HI_OFS) exp_rd = 8'h00;
      host_u.write_reg(8'(a), 8'h5A ^ 8'(a));
      chk_reg(8'(a), exp_rd);
    end
    $display("test register_map done");
    foreach (codes[i]) begin
      emitter_drive_t exp_drv;
      exp_drv = '{one: ~codes[i], two: codes[i], three: codes[i]};
      host_u.write_reg(EMIT_ONE_TWO_OFS, {codes[i], ~codes[i]});
      host_u.write_reg(EMIT_THREE_OFS, {4'hF, codes[i]});
      @(negedge clk) prox_act <= 1'b1;
      @(negedge clk) `CHK("drive", exp_drv, drive)
      @(negedge clk) prox_act <= 1'b0;
      @(negedge clk) `CHK("idle drive", 12'h000, drive)
    end
    $display("test emitters done");
    host_u.write_reg(PROX_ONE_LO_OFS, 8'h00);
    host_u.write_reg(PROX_ONE_HI_OFS, 8'h02);
    m_prox(16'h0200, 1'b0);
    m_prox(16'h0201, 1'b1);
    // Only the low byte changes: the new byte counts at once.
    host_u.write_reg(PROX_ONE_LO_OFS, 8'hFF);
    m_prox(16'h0201, 1'b0);
    host_u.write_reg(AMB_LOWER_LO_OFS, 8'h00);
    host_u.write_reg(AMB_LOWER_HI_OFS, 8'h01);
    host_u.write_reg(AMB_UPPER_LO_OFS, 8'h00);
    host_u.write_reg(AMB_UPPER_HI_OFS, 8'h03);
    m_amb(1'b0, 16'h0300, 16'h0000, 1'b0);
    m_amb(1'b0, 16'h0301, 16'h0200, 1'b1);
    m_amb(1'b1, 16'h0200, 16'h00FF, 1'b1);
    m_amb(1'b1, 16'h0000, 16'h0100, 1'b0);
    $display("test comparators done");
    @(negedge clk) legacy = 1'b1;
    host_u.write_reg(PROX_ONE_LO_OFS, 8'h40);
    host_u.write_reg(AMB_UPPER_LO_OFS, 8'h40);
    m_prox(16'h0011, 1'b1);
    m_prox(16'h0010, 1'b0);
    m_amb(1'b0, 16'h0011, 16'h0008, 1'b1);
    m_amb(1'b0, 16'h0008, 16'hFFFF, 1'b0);
    $display("test legacy done");
    @(negedge clk) rst_b = 1'b0;
    @(negedge clk) rst_b = 1'b1;
    chk_reg(EMIT_ONE_TWO_OFS, 8'h00);
    $display("test second_reset done");
    end_of_test();
  end
endmodule : sensor_threshold_led_regs_test
